//--- rtl/acp_pkg.sv
package acp_pkg;
   // ASCII characters the parser and the response builder act on
   localparam logic [7:0] ACP_SP   = 8'h20;
   localparam logic [7:0] ACP_QT   = 8'h22;
   localparam logic [7:0] ACP_BS   = 8'h5C;
   localparam logic [7:0] ACP_CM   = 8'h2C;
   localparam logic [7:0] ACP_CO   = 8'h3A;
   localparam logic [7:0] ACP_SC   = 8'h3B;
   localparam logic [7:0] ACP_CR   = 8'h0D;
   localparam logic [7:0] ACP_LF   = 8'h0A;
   localparam logic [7:0] ACP_ETX  = 8'h03;
   localparam logic [7:0] ACP_UA   = 8'h41;
   localparam logic [7:0] ACP_UZ   = 8'h5A;
   localparam logic [7:0] ACP_CASE = 8'h20;

   typedef enum logic [2:0] {
      ACP_EOF_COMMA = 3'h0,
      ACP_EOF_COLON = 3'h1,
      ACP_EOF_SEMI  = 3'h2,
      ACP_EOF_CR    = 3'h3,
      ACP_EOF_CRLF  = 3'h4,
      ACP_EOF_LFCR  = 3'h5,
      ACP_EOF_ETX   = 3'h6
   } acp_eof_e;

   // Command words, lower case, right aligned
   localparam int          ACP_CMD_W  = 48;
   localparam int          ACP_CLEN_W = 3;
   localparam logic [2:0]  ACP_CLEN_MAX = 3'h7;
   localparam logic [47:0] ACP_W_GET    = 48'h0000_0067_6574;
   localparam logic [47:0] ACP_W_SET    = 48'h0000_0073_6574;
   localparam logic [47:0] ACP_W_DO     = 48'h0000_0000_646F;
   localparam logic [47:0] ACP_W_LOGIN  = 48'h006C_6F67_696E;
   localparam logic [47:0] ACP_W_LOGOUT = 48'h6C6F_676F_7574;
   localparam logic [2:0]  ACP_L_GET    = 3'h3;
   localparam logic [2:0]  ACP_L_SET    = 3'h3;
   localparam logic [2:0]  ACP_L_DO     = 3'h2;
   localparam logic [2:0]  ACP_L_LOGIN  = 3'h5;
   localparam logic [2:0]  ACP_L_LOGOUT = 3'h6;
   localparam logic [4:0]  ACP_C_NONE   = 5'h00;
   localparam logic [4:0]  ACP_C_GET    = 5'h01;
   localparam logic [4:0]  ACP_C_SET    = 5'h02;
   localparam logic [4:0]  ACP_C_DO     = 5'h04;
   localparam logic [4:0]  ACP_C_LOGIN  = 5'h08;
   localparam logic [4:0]  ACP_C_LOGOUT = 5'h10;

   typedef enum logic [2:0] {
      ACP_M_OK   = 3'h0,
      ACP_M_MISS = 3'h1,
      ACP_M_UNK  = 3'h2,
      ACP_M_QQ   = 3'h3,
      ACP_M_NONE = 3'h4
   } acp_msg_e;

   localparam int          ACP_OK_LEN  = 2;
   localparam int          ACP_ERR_LEN = 27;
   localparam logic [15:0] ACP_S_OK    = "OK";
   localparam logic [15:0] ACP_S_QQ    = "\"\"";
   localparam logic [215:0] ACP_S_MISS = "ERROR 10000_MISSING_COMMAND";
   localparam logic [215:0] ACP_S_UNK  = "ERROR 10001_UNKNOWN_COMMAND";

   // Partial request frames and undrained response frames stall after this long without progress
   localparam int ACP_CLK_NS   = 100;
   localparam int ACP_STALL_US = 1000;
   localparam int ACP_STALL_CYC = ACP_STALL_US * 1000 / ACP_CLK_NS;
   localparam int ACP_CNT_W    = 16;
   localparam int ACP_FIFO_D   = 4;

   function automatic logic [4:0] acp_msg_len(acp_msg_e m);
      case (m)
         ACP_M_OK, ACP_M_QQ:    return 5'(ACP_OK_LEN);
         ACP_M_MISS, ACP_M_UNK: return 5'(ACP_ERR_LEN);
         default:               return 5'h00;
      endcase
   endfunction

   function automatic logic [7:0] acp_msg_chr(acp_msg_e m, logic [4:0] i);
      case (m)
         ACP_M_OK:   return ACP_S_OK[8*(ACP_OK_LEN-1-int'(i)) +: 8];
         ACP_M_QQ:   return ACP_S_QQ[8*(ACP_OK_LEN-1-int'(i)) +: 8];
         ACP_M_MISS: return ACP_S_MISS[8*(ACP_ERR_LEN-1-int'(i)) +: 8];
         ACP_M_UNK:  return ACP_S_UNK[8*(ACP_ERR_LEN-1-int'(i)) +: 8];
         default:    return ACP_SP;
      endcase
   endfunction

   function automatic logic acp_eof_two(acp_eof_e s);
      return (s == ACP_EOF_CRLF) || (s == ACP_EOF_LFCR);
   endfunction

   function automatic logic [7:0] acp_eof_chr(acp_eof_e s, logic i);
      case (s)
         ACP_EOF_COMMA: return ACP_CM;
         ACP_EOF_COLON: return ACP_CO;
         ACP_EOF_SEMI:  return ACP_SC;
         ACP_EOF_CR:    return ACP_CR;
         ACP_EOF_CRLF:  return i ? ACP_LF : ACP_CR;
         ACP_EOF_LFCR:  return i ? ACP_CR : ACP_LF;
         default:       return ACP_ETX;
      endcase
   endfunction

   function automatic logic [7:0] acp_lower(logic [7:0] b);
      return (b >= ACP_UA && b <= ACP_UZ) ? (b | ACP_CASE) : b;
   endfunction
endpackage

//--- rtl/acp_link_if.sv
`timescale 1ns/1ps
interface acp_link_if;
   logic       rq_vld;
   logic [7:0] rq_data;
   logic       rq_par;
   logic       rq_stop;
   logic       rq_rdy;
   logic       rs_vld;
   logic [7:0] rs_data;
   logic       rs_rdy;
   modport dev  (input rq_vld, rq_data, rq_par, rq_stop, rs_rdy,
                 output rq_rdy, rs_vld, rs_data);
   modport host (output rq_vld, rq_data, rq_par, rq_stop, rs_rdy,
                 input rq_rdy, rs_vld, rs_data);
endinterface

//--- rtl/acp_fifo.sv
`timescale 1ns/1ps
module acp_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         nrst,
   input  wire logic         in_vld,
   output logic              in_rdy,
   input  wire logic [W-1:0] in_data,
   output logic              out_vld,
   input  wire logic         out_rdy,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_ff [D];
   logic [AW:0]  wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic         push, pop;

   assign in_rdy   = (wr_ff - rd_ff) != (AW+1)'(D);
   assign out_vld  = wr_ff != rd_ff;
   assign out_data = mem_ff[rd_ff[AW-1:0]];
   assign push     = in_vld && in_rdy;
   assign pop      = out_vld && out_rdy;

   always_comb begin
      nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
      nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         wr_ff <= '0;
         rd_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
      end
   end

   // Storage needs no reset; empty flag guards it
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_ff[wr_ff[AW-1:0]] <= in_data;
      end
   end
endmodule // acp_fifo

//--- rtl/acp_dev.sv
`timescale 1ns/1ps
module acp_dev
   import acp_pkg::*;
#(
   parameter int STALL_CYC = acp_pkg::ACP_STALL_CYC
) (
   acp_link_if.dev                    lnk,
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   input  wire acp_pkg::acp_eof_e     eof_sel,
   input  wire logic                  str_none,
   output logic                       exe_req,
   output logic [4:0]                 exe_cmd,
   input  wire logic                  exe_ack,
   output logic [acp_pkg::ACP_CNT_W-1:0] err_cnt,
   output logic                       req_fail,
   output logic                       stall,
   output logic                       par_err,
   output logic                       brk_err,
   output logic                       frm_err
);
   typedef enum logic [3:0] {
      ACP_S_RX  = 4'b0001,
      ACP_S_EXE = 4'b0010,
      ACP_S_MSG = 4'b0100,
      ACP_S_EOF = 4'b1000
   } acp_st_e;

   acp_st_e              st_ff, nxt_st;
   logic [1:0]           tok_ff, nxt_tok;
   logic                 has_ff, nxt_has, inq_ff, nxt_inq, esc_ff, nxt_esc;
   logic                 pend_ff, nxt_pend, any_ff, nxt_any;
   logic [ACP_CMD_W-1:0] cmd_ff, nxt_cmdw;
   logic [2:0]           clen_ff, nxt_clen;
   acp_msg_e             msg_ff, nxt_msg;
   logic [4:0]           idx_ff, nxt_idx;
   logic                 two_ff, nxt_two, req_ff, nxt_req, rdy_ff, nxt_rdy;
   logic [4:0]           xcmd_ff, nxt_xcmd;
   logic [ACP_CNT_W-1:0] ecnt_ff, nxt_ecnt, scnt_ff, nxt_scnt;
   logic                 fail_ff, nxt_fail, stall_ff, nxt_stall;
   logic                 pe_ff, be_ff, fe_ff, nxt_pe, nxt_be, nxt_fe;
   logic                 ovld_ff, nxt_ovld;
   logic [7:0]           odat_ff, nxt_odat;
   logic                 take, bad, hit, content, active;
   logic [7:0]           b;
   logic [4:0]           code;
   logic                 push_vld, push_rdy, f_vld, f_rdy;
   logic [7:0]           push_dat, f_dat;

   assign lnk.rq_rdy  = rdy_ff;
   assign lnk.rs_vld  = ovld_ff;
   assign lnk.rs_data = odat_ff;
   assign exe_req  = req_ff;
   assign exe_cmd  = xcmd_ff;
   assign err_cnt  = ecnt_ff;
   assign req_fail = fail_ff;
   assign stall    = stall_ff;
   assign par_err  = pe_ff;
   assign brk_err  = be_ff;
   assign frm_err  = fe_ff;

   // Response path buffer; a slow reader backs up into the builder
   acp_fifo #(.W(8), .D(ACP_FIFO_D)) u_fifo (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .in_vld  (push_vld),
      .in_rdy  (push_rdy),
      .in_data (push_dat),
      .out_vld (f_vld),
      .out_rdy (f_rdy),
      .out_data(f_dat)
   );
   assign f_rdy = !ovld_ff || lnk.rs_rdy;

   always_comb begin
      code = ACP_C_NONE;
      if (clen_ff == ACP_L_GET && cmd_ff == ACP_W_GET) code = ACP_C_GET;
      if (clen_ff == ACP_L_SET && cmd_ff == ACP_W_SET) code = ACP_C_SET;
      if (clen_ff == ACP_L_DO && cmd_ff == ACP_W_DO) code = ACP_C_DO;
      if (clen_ff == ACP_L_LOGIN && cmd_ff == ACP_W_LOGIN) code = ACP_C_LOGIN;
      if (clen_ff == ACP_L_LOGOUT && cmd_ff == ACP_W_LOGOUT) code = ACP_C_LOGOUT;
   end

   assign push_vld = (st_ff == ACP_S_MSG && idx_ff < acp_msg_len(msg_ff)) || st_ff == ACP_S_EOF;
   assign push_dat = (st_ff == ACP_S_MSG) ? acp_msg_chr(msg_ff, idx_ff)
                                          : acp_eof_chr(eof_sel, idx_ff[0]);

   always_comb begin
      nxt_st = st_ff;    nxt_tok = tok_ff;   nxt_has = has_ff;   nxt_inq = inq_ff;
      nxt_esc = esc_ff;  nxt_pend = pend_ff; nxt_any = any_ff;   nxt_cmdw = cmd_ff;
      nxt_clen = clen_ff; nxt_msg = msg_ff;  nxt_idx = idx_ff;   nxt_two = two_ff;
      nxt_req = req_ff;  nxt_xcmd = xcmd_ff; nxt_ecnt = ecnt_ff; nxt_fail = 1'b0;
      nxt_scnt = scnt_ff; nxt_stall = stall_ff;
      take = lnk.rq_vld && rdy_ff;
      b = lnk.rq_data;
      // even parity, break is all-zero character
      nxt_pe = take && (^{b, lnk.rq_par});
      nxt_be = take && !lnk.rq_stop && b == '0 && !lnk.rq_par;
      nxt_fe = take && !lnk.rq_stop && !nxt_be;
      bad = nxt_pe || nxt_be || nxt_fe;
      hit = 1'b0;
      content = 1'b0;
      case (st_ff)
         ACP_S_RX: begin
            if (take && !bad) begin
               nxt_any = 1'b1;
               nxt_pend = 1'b0;
               if (!inq_ff && !esc_ff && !acp_eof_two(eof_sel) && b == acp_eof_chr(eof_sel, 1'b0))
                  hit = 1'b1;
               else if (!inq_ff && !esc_ff && pend_ff && b == acp_eof_chr(eof_sel, 1'b1))
                  hit = 1'b1;
               else if (!inq_ff && !esc_ff && acp_eof_two(eof_sel) &&
                        b == acp_eof_chr(eof_sel, 1'b0))
                  nxt_pend = 1'b1;
               else if (esc_ff) begin
                  nxt_esc = 1'b0;
                  content = 1'b1;
               end else if (inq_ff) begin
                  if (b == ACP_BS) nxt_esc = 1'b1;
                  else if (b == ACP_QT) nxt_inq = 1'b0;
                  else content = 1'b1;
               // quote is plain text when strings undelimited
               end else if (b == ACP_QT && !str_none) begin
                  nxt_inq = 1'b1;
                  nxt_has = 1'b1;
               end else if (b == ACP_SP) begin
                  if (has_ff && tok_ff != 2'h3) nxt_tok = tok_ff + 2'h1;
                  nxt_has = 1'b0;
               end else content = 1'b1;
               // command word folded to lower case
               if (content) begin
                  nxt_has = 1'b1;
                  if (tok_ff == 2'h0 && clen_ff != ACP_CLEN_MAX) begin
                     nxt_cmdw = {cmd_ff[ACP_CMD_W-9:0], acp_lower(b)};
                     nxt_clen = clen_ff + 3'h1;
                  end
               end
            end
            // work starts only on the delimiter
            if (hit) begin
               nxt_tok = '0; nxt_has = 1'b0; nxt_inq = 1'b0; nxt_esc = 1'b0;
               nxt_any = 1'b0; nxt_cmdw = '0; nxt_clen = '0; nxt_idx = '0;
               nxt_two = 1'b0;
               if (clen_ff == '0) begin
                  nxt_msg = ACP_M_MISS;
                  nxt_st = ACP_S_MSG;
               // unknown word gets its own code
               end else if (code == ACP_C_NONE) begin
                  nxt_msg = ACP_M_UNK;
                  nxt_st = ACP_S_MSG;
               end else begin
                  nxt_req = 1'b1;
                  nxt_xcmd = code;
                  nxt_two = (code == ACP_C_GET);
                  nxt_st = ACP_S_EXE;
               end
               if (clen_ff == '0 || code == ACP_C_NONE) begin
                  nxt_fail = 1'b1;
                  nxt_ecnt = ecnt_ff + 1'b1;
               end
            end
         end
         ACP_S_EXE: begin
            if (exe_ack) begin
               nxt_req = 1'b0;
               nxt_msg = ACP_M_OK;
               nxt_st = ACP_S_MSG;
            end
         end
         ACP_S_MSG: begin
            if (idx_ff == acp_msg_len(msg_ff)) begin
               nxt_idx = '0;
               nxt_st = ACP_S_EOF;
            end else if (push_rdy) nxt_idx = idx_ff + 5'h1;
         end
         ACP_S_EOF: begin
            if (push_rdy) begin
               if (idx_ff[0] == acp_eof_two(eof_sel)) begin
                  nxt_idx = '0;
                  if (two_ff) begin
                     nxt_two = 1'b0;
                     nxt_msg = str_none ? ACP_M_NONE : ACP_M_QQ;
                     nxt_st = ACP_S_MSG;
                  end else nxt_st = ACP_S_RX;
               end else nxt_idx = idx_ff + 5'h1;
            end
         end
         default: nxt_st = ACP_S_RX;
      endcase
      // partial frame idle or response not drained
      active = (st_ff == ACP_S_RX && any_ff && !hit) ||
               ((st_ff == ACP_S_MSG || st_ff == ACP_S_EOF) && !push_rdy);
      if (take || !active) begin
         nxt_scnt = '0;
         nxt_stall = 1'b0;
      end else if (scnt_ff == ACP_CNT_W'(STALL_CYC - 1)) nxt_stall = 1'b1;
      else nxt_scnt = scnt_ff + 1'b1;
      nxt_rdy = (nxt_st == ACP_S_RX);
      nxt_ovld = f_rdy ? f_vld : ovld_ff;
      nxt_odat = (f_rdy && f_vld) ? f_dat : odat_ff;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= ACP_S_RX;   tok_ff <= '0;  has_ff <= 1'b0;  inq_ff <= 1'b0;
         esc_ff <= 1'b0;      pend_ff <= 1'b0; any_ff <= 1'b0; cmd_ff <= '0;
         clen_ff <= '0;       msg_ff <= ACP_M_OK; idx_ff <= '0; two_ff <= 1'b0;
         req_ff <= 1'b0;      xcmd_ff <= ACP_C_NONE; ecnt_ff <= '0; fail_ff <= 1'b0;
         scnt_ff <= '0;       stall_ff <= 1'b0; pe_ff <= 1'b0; be_ff <= 1'b0;
         fe_ff <= 1'b0;       rdy_ff <= 1'b0; ovld_ff <= 1'b0; odat_ff <= '0;
      end else begin
         st_ff <= nxt_st;     tok_ff <= nxt_tok; has_ff <= nxt_has; inq_ff <= nxt_inq;
         esc_ff <= nxt_esc;   pend_ff <= nxt_pend; any_ff <= nxt_any; cmd_ff <= nxt_cmdw;
         clen_ff <= nxt_clen; msg_ff <= nxt_msg; idx_ff <= nxt_idx; two_ff <= nxt_two;
         req_ff <= nxt_req;   xcmd_ff <= nxt_xcmd; ecnt_ff <= nxt_ecnt; fail_ff <= nxt_fail;
         scnt_ff <= nxt_scnt; stall_ff <= nxt_stall; pe_ff <= nxt_pe; be_ff <= nxt_be;
         fe_ff <= nxt_fe;     rdy_ff <= nxt_rdy; ovld_ff <= nxt_ovld; odat_ff <= nxt_odat;
      end
   end
endmodule // acp_dev

//--- rtl/acp_host.sv
`timescale 1ns/1ps
module acp_host
   import acp_pkg::*;
(
   acp_link_if.host               lnk,
   input  wire logic              ref_clk,
   input  wire logic              nrst,
   input  wire acp_pkg::acp_eof_e eof_sel,
   input  wire logic              usr_vld,
   input  wire logic [7:0]        usr_data,
   input  wire logic              usr_str,
   input  wire logic              usr_last,
   output logic                   usr_rdy,
   output logic                   rsp_vld,
   output logic [7:0]             rsp_data,
   output logic                   rsp_end
);
   typedef enum logic [3:0] {
      ACP_H_SEND = 4'b0001,
      ACP_H_ESC  = 4'b0010,
      ACP_H_EOF  = 4'b0100,
      ACP_H_WAIT = 4'b1000
   } acp_hst_e;

   acp_hst_e    st_ff, nxt_st;
   logic        tvld_ff, nxt_tvld, urdy_ff, nxt_urdy, srdy_ff, nxt_srdy;
   logic [7:0]  tdat_ff, nxt_tdat, hold_ff, nxt_hold, rdat_ff, nxt_rdat;
   logic        last_ff, nxt_last, idx_ff, nxt_idx, pend_ff, nxt_pend;
   logic [23:0] cw_ff, nxt_cw;
   logic [1:0]  cn_ff, nxt_cn, left_ff, nxt_left;
   logic        done_ff, nxt_done, rv_ff, nxt_rv, re_ff, nxt_re;
   logic        par_ff, nxt_par;
   logic        free, acc, rtake;

   assign lnk.rq_vld  = tvld_ff;
   assign lnk.rq_data = tdat_ff;
   assign lnk.rq_par  = par_ff;
   assign lnk.rq_stop = 1'b1;
   assign lnk.rs_rdy  = srdy_ff;
   assign usr_rdy  = urdy_ff;
   assign rsp_vld  = rv_ff;
   assign rsp_data = rdat_ff;
   assign rsp_end  = re_ff;

   always_comb begin
      nxt_st = st_ff;   nxt_tvld = tvld_ff; nxt_tdat = tdat_ff; nxt_hold = hold_ff;
      nxt_last = last_ff; nxt_idx = idx_ff; nxt_pend = pend_ff; nxt_cw = cw_ff;
      nxt_cn = cn_ff;   nxt_left = left_ff; nxt_done = done_ff;
      nxt_rv = 1'b0;    nxt_re = 1'b0;      nxt_rdat = rdat_ff;
      free = !tvld_ff || lnk.rq_rdy;
      if (tvld_ff && lnk.rq_rdy) nxt_tvld = 1'b0;
      acc = usr_vld && urdy_ff;
      rtake = lnk.rs_vld && srdy_ff;
      case (st_ff)
         ACP_H_SEND: begin
            if (acc) begin
               nxt_tvld = 1'b1;
               nxt_last = usr_last;
               // Track the command word to know how many frames follow
               // Leading spaces skipped; a fourth letter spoils the match
               if (usr_data == ACP_SP) begin
                  if (cn_ff != '0) nxt_done = 1'b1;
               end else if (!done_ff) begin
                  if (cn_ff != 2'h3) begin
                     nxt_cw = {cw_ff[15:0], acp_lower(usr_data)};
                     nxt_cn = cn_ff + 2'h1;
                  end else begin
                     nxt_cw = '0;
                     nxt_done = 1'b1;
                  end
               end
               // escape quote and backslash inside strings
               if (usr_str && (usr_data == ACP_QT || usr_data == ACP_BS)) begin
                  nxt_tdat = ACP_BS;
                  nxt_hold = usr_data;
                  nxt_st = ACP_H_ESC;
               end else begin
                  nxt_tdat = usr_data;
                  if (usr_last) nxt_st = ACP_H_EOF;
               end
            end
         end
         ACP_H_ESC: begin
            if (free) begin
               nxt_tvld = 1'b1;
               nxt_tdat = hold_ff;
               nxt_st = last_ff ? ACP_H_EOF : ACP_H_SEND;
            end
         end
         ACP_H_EOF: begin
            // frame closed by the shared delimiter
            if (free) begin
               nxt_tvld = 1'b1;
               nxt_tdat = acp_eof_chr(eof_sel, idx_ff);
               if (idx_ff == acp_eof_two(eof_sel)) begin
                  nxt_idx = 1'b0;
                  nxt_left = (cn_ff == 2'h3 && cw_ff == ACP_W_GET[23:0]) ? 2'h2 : 2'h1;
                  nxt_st = ACP_H_WAIT;
               end else nxt_idx = 1'b1;
            end
         end
         ACP_H_WAIT: begin
            if (rtake) begin
               nxt_rv = 1'b1;
               nxt_rdat = lnk.rs_data;
               nxt_pend = 1'b0;
               if ((!acp_eof_two(eof_sel) || pend_ff) &&
                   lnk.rs_data == acp_eof_chr(eof_sel, pend_ff)) begin
                  nxt_re = 1'b1;
                  nxt_left = left_ff - 2'h1;
                  // next request only after all frames
                  if (left_ff == 2'h1) begin
                     nxt_st = ACP_H_SEND;
                     nxt_cw = '0;
                     nxt_cn = '0;
                     nxt_done = 1'b0;
                  end
               end else if (acp_eof_two(eof_sel) && lnk.rs_data == acp_eof_chr(eof_sel, 1'b0))
                  nxt_pend = 1'b1;
            end
         end
         default: nxt_st = ACP_H_SEND;
      endcase
      nxt_urdy = (nxt_st == ACP_H_SEND) && !nxt_tvld;
      // Response side opens only once the delimiter has left
      nxt_srdy = (nxt_st == ACP_H_WAIT) && !nxt_tvld;
      nxt_par = ^nxt_tdat;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= ACP_H_SEND; tvld_ff <= 1'b0; tdat_ff <= '0; hold_ff <= '0;
         last_ff <= 1'b0; idx_ff <= 1'b0; pend_ff <= 1'b0; cw_ff <= '0;
         cn_ff <= '0; left_ff <= '0; done_ff <= 1'b0; rv_ff <= 1'b0;
         re_ff <= 1'b0; rdat_ff <= '0; urdy_ff <= 1'b0; srdy_ff <= 1'b0;
         par_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st; tvld_ff <= nxt_tvld; tdat_ff <= nxt_tdat; hold_ff <= nxt_hold;
         last_ff <= nxt_last; idx_ff <= nxt_idx; pend_ff <= nxt_pend; cw_ff <= nxt_cw;
         cn_ff <= nxt_cn; left_ff <= nxt_left; done_ff <= nxt_done; rv_ff <= nxt_rv;
         re_ff <= nxt_re; rdat_ff <= nxt_rdat; urdy_ff <= nxt_urdy; srdy_ff <= nxt_srdy;
         par_ff <= nxt_par;
      end
   end
endmodule // acp_host

//--- sim/acp_asserts.sv
`timescale 1ns/1ps
module acp_asserts (
   input wire logic       ref_clk,
   input wire logic       nrst,
   input wire logic       rq_vld,
   input wire logic [7:0] rq_data,
   input wire logic       rq_par,
   input wire logic       rq_stop,
   input wire logic       rq_rdy,
   input wire logic       rs_vld,
   input wire logic [7:0] rs_data,
   input wire logic       rs_rdy
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Shortest first response frame is two chars plus a delimiter
   sequence busy_hold;
      !rq_rdy [*3];
   endsequence
   chk_rq_hold: assert property (rq_vld && !rq_rdy |=> rq_vld && $stable(rq_data))
      else $error("request char dropped");
   chk_rs_hold: assert property (rs_vld && !rs_rdy |=> rs_vld && $stable(rs_data))
      else $error("response char dropped");
   chk_par_even: assert property (rq_vld |-> !(^{rq_data, rq_par}))
      else $error("odd parity sent");
   chk_stop_good: assert property (rq_vld |-> rq_stop)
      else $error("bad stop bit sent");
   chk_busy_cause: assert property ($fell(rq_rdy) |-> $past(rq_vld) && $past(rq_rdy))
      else $error("busy with no char taken");
   chk_busy_min: assert property ($fell(rq_rdy) |-> busy_hold)
      else $error("busy too short");
   chk_ready_back: assert property ($fell(rq_rdy) |-> ##[3:300] rq_rdy)
      else $error("device never ready again");
   chk_quiet_idle: assert property (rq_rdy [*8] |-> !rs_vld)
      else $error("response without request");
   chk_no_overlap: assert property (rs_rdy |-> !rq_vld)
      else $error("request while waiting");
endmodule // acp_asserts

//--- sim/acp_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module acp_tb;
   import acp_pkg::*;
   logic       ref_clk = 0, nrst = 0, str_none = 0, exe_ack = 0, usr_vld = 0, usr_last = 0;
   logic       usr_rdy, rsp_vld, rsp_end, exe_req, usr_str = 0;
   logic       req_fail, stall, par_err, brk_err, frm_err;
   logic [7:0] usr_data = 8'h00, rsp_data;
   logic [4:0] exe_cmd, cmd_seen;
   logic [15:0] err_cnt;
   acp_eof_e   eof_sel = ACP_EOF_CR;
   int         num_errors = 0, tests_run = 0, nfr = 0, nfail = 0, nperr = 0;
   string      got;
   string      dl[7] = '{",", ":", ";", "\015", "\015\012", "\012\015", "\003"};
   string      cw[4] = '{"do x", "SET a b 1", "Login", "logout"};
   logic [4:0] cc[4] = '{ACP_C_DO, ACP_C_SET, ACP_C_LOGIN, ACP_C_LOGOUT};
   acp_link_if lnk ();
   acp_dev #(.STALL_CYC(16)) u_acp_dev (.lnk(lnk), .ref_clk, .nrst, .eof_sel, .str_none,
      .exe_req, .exe_cmd, .exe_ack, .err_cnt, .req_fail, .stall, .par_err, .brk_err,
      .frm_err);
   acp_host u_acp_host (.lnk(lnk), .ref_clk, .nrst, .eof_sel, .usr_vld, .usr_data,
      .usr_str, .usr_last, .usr_rdy, .rsp_vld, .rsp_data, .rsp_end);
   acp_asserts u_acp_asserts (.ref_clk, .nrst, .rq_vld(lnk.rq_vld), .rq_data(lnk.rq_data),
      .rq_par(lnk.rq_par), .rq_stop(lnk.rq_stop), .rq_rdy(lnk.rq_rdy),
      .rs_vld(lnk.rs_vld), .rs_data(lnk.rs_data), .rs_rdy(lnk.rs_rdy));
   initial forever #50 ref_clk = ~ref_clk;
   always @(negedge ref_clk) exe_ack <= exe_req;
   always @(posedge ref_clk) begin
      if (exe_req === 1'b1) cmd_seen <= exe_cmd;
      if (rsp_vld === 1'b1) got = {got, string'(rsp_data)};
      if (rsp_end === 1'b1) nfr++;
      if (req_fail === 1'b1) nfail++;
      if (nrst && (par_err | brk_err | frm_err) !== 1'b0) nperr++;
   end
   task automatic end_sim;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic run(string s, int nf, string exp, int gap = -1);
      int q0 = -1;
      int q1 = -1;
      got = "";
      nfr = 0;
      // Bytes strictly inside the outer quotes are string content
      for (int i = 0; i < s.len(); i++) begin
         if (s[i] == ACP_QT) begin
            if (q0 < 0) q0 = i;
            q1 = i;
         end
      end
      for (int i = 0; i < s.len(); i++) begin
         // Pause mid-frame so the partial request goes stale
         if (i == gap) begin
            @(negedge ref_clk);
            usr_vld = 0;
            repeat (30) @(negedge ref_clk);
            `CHK("stall", 1'b1, stall)
         end
         @(negedge ref_clk);
         usr_vld = 1;
         usr_data = s[i];
         usr_str = (i > q0 && i < q1);
         usr_last = (i == s.len() - 1);
         while (usr_rdy !== 1'b1) @(negedge ref_clk);
      end
      @(negedge ref_clk);
      usr_vld = 0;
      for (int t = 0; t < 400 && nfr < nf; t++) @(negedge ref_clk);
      `CHK(s, 1'b1, got == exp)
      `CHK("idle", 1'b0, stall)
   endtask
   initial begin
      repeat (6) @(negedge ref_clk);
      nrst = 1;
      repeat (2) @(negedge ref_clk);
      for (int e = 0; e < 7; e++) begin
         eof_sel = acp_eof_e'(e);
         run("GeT a b", 2, {"OK", dl[e], "\"\"", dl[e]});
         `CHK("get", ACP_C_GET, cmd_seen)
      end
      eof_sel = ACP_EOF_CRLF;
      for (int i = 0; i < 4; i++) begin
         run(cw[i], 1, {"OK", dl[4]});
         `CHK("cmd", cc[i], cmd_seen)
      end
      run("do y", 1, {"OK", dl[4]}, 2);
      run("set a b \"x\"y\"", 1, {"OK", dl[4]});
      `CHK("set", ACP_C_SET, cmd_seen)
      run("xyz", 1, {"ERROR 10001_UNKNOWN_COMMAND", dl[4]});
      run(" ", 1, {"ERROR 10000_MISSING_COMMAND", dl[4]});
      `CHK("errs", 16'h0002, err_cnt)
      `CHK("fails", 2, nfail)
      str_none = 1;
      run("get a", 2, {"OK", dl[4], dl[4]});
      `CHK("port", 0, nperr)
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      end_sim;
   end
endmodule // acp_tb
